// [aual_host_model.sv]
// host cpu model: reads words of the unit block and pulses the commit bit
// assumes the bench raises commit_req for one cycle, all in the MCLK domain
`timescale 1ns/1ps
`default_nettype none
module aual_host_model (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [6:0] unit_num,
  input wire logic [3:0] rd_ofs,
  input wire logic commit_req,
  output logic [13:0] rd_word,
  output logic adj_apply
);
  // ========================================
  // word address: base plus ten per unit plus offset
  always_comb begin
    rd_word = 14'h07D0 + 14'h000A * {7'h00, unit_num} + {10'h000, rd_ofs};
  end
  // commit bit turned on for one cycle, then off again
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      adj_apply <= 1'b0;
    end else begin
      adj_apply <= commit_req;
    end
  end
endmodule : aual_host_model
`default_nettype wire

// [aual_pkg.sv]
// package for the analog unit alarm/status block
// assumes a single module clock and a restart pulse from the host side
package aual_pkg;
  // word block placement
  localparam int unsigned BASE_WORD = 2000;
  localparam int unsigned UNIT_STRIDE = 10;
  localparam logic [3:0] ALARM_WORD_OFS = 4'h9;
  localparam logic [3:0] CTRL_WORD_OFS = 4'h1;
  localparam logic [3:0] MON_WORD_OFS = 4'h8;
  // alarm status word bit positions
  localparam int OUT_ERR_LSB = 0;
  localparam int WIRE_ERR_LSB = 4;
  localparam int RATIO_USE_BIT = 8;
  localparam int RATIO_VAL_BIT = 9;
  localparam int HOLD_SEL_BIT = 10;
  localparam int AVG_SEL_BIT = 11;
  localparam int ADJ_RANGE_BIT = 12;
  localparam int ADJ_CHAN_BIT = 13;
  localparam int NV_FAIL_BIT = 14;
  localparam int ADJ_MODE_BIT = 15;
  localparam logic [3:0] COMMIT_BIT = 4'h4;
  // setting limits
  localparam logic [15:0] HOLD_SEL_MAX = 16'h0002;
  localparam logic [15:0] AVG_SEL_MAX = 16'h0006;
  localparam logic [15:0] ZERO_DATA = 16'h0000;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  // adjust indicator blink half period
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  // input range codes
  typedef enum logic [1:0] {AUAL_RNG_10V, AUAL_RNG_PM10V, AUAL_RNG_1_5V, AUAL_RNG_0_5V} aual_rng_e;
  // initial settings carried together
  typedef struct packed {
    logic [15:0] ratio_val;
    logic [15:0] hold_sel;
    logic [15:0] avg_sel;
    logic ratio_use;
    logic ratio_chan_used;
  } aual_setup_s;
  // adjustment request carried together
  typedef struct packed {
    logic [7:0] chan;
    logic chan_enabled;
    logic in_window;
    logic nv_fail;
  } aual_adj_s;
endpackage : aual_pkg

// [aual_status.sv]
// alarm status word and front panel indicators of an analog I/O unit
// assumes settings are static between restarts and inputs are synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none

// Function
// - run lamp on in normal operation, off once host data exchange stops
// - unit alarm lamp on for any alarm or bad initial setting; during host monitor/run in adjust only a setup fault lights it
// - adjust lamp flashes in adjustment mode only
// - host fault lamp on for host exchange fault, off otherwise
// - alarms light unit alarm lamp and set flags in bits 00-14
// - normal-operation alarm flags clear themselves when the condition goes
// - bits 00-03 flag out-of-range output; output takes hold-setting value
// - bits 04-07 flag broken input wire; conversion result forced to 0000
// - broken wire checked only for 1-5 V / 4-20 mA inputs
// - failed nonvolatile write sets bit 14, output held; host retoggles commit
// - bit 15 stays set while adjustment mode is active
// - input outside adjust window sets bit 12, change refused, live data shown
// - bad or disabled adjust channel sets bit 13, nothing changes
// - host monitor/run during adjust shows bit 15 alone, freezes I/O
// - setup faults light alarm, run dark, clear only on restart after fix
// - ratio function naming unused channel sets bit 08, data 0000
// - ratio value not BCD 0-9999 sets bit 09, unconverted
// - hold selection above 0002 sets bit 10, unconverted
// - averaging code above 0006 sets bit 11, unconverted
// - word block at 2000 plus ten times unit; status at plus 9
module aual_status #(
  parameter int unsigned BLINK_CYCLES = aual_pkg::BLINK_CYC,
  parameter int unsigned N_IN = 4,
  parameter int unsigned N_OUT = 4
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic RESTART,
  input wire logic [6:0] UNIT_NUM,
  input wire logic HOST_OK,
  input wire logic HOST_FAULT,
  input wire logic ADJ_SWITCH,
  input wire logic HOST_PROG_MODE,
  input wire logic [N_IN*2-1:0] IN_RANGE,
  input wire logic [N_IN-1:0] IN_WIRE_OPEN,
  input wire logic [N_IN*16-1:0] IN_DATA,
  input wire logic [N_OUT-1:0] OUT_OVER,
  input wire logic [N_OUT*16-1:0] OUT_SET,
  input wire logic [N_OUT*16-1:0] OUT_HOLD_VAL,
  input wire aual_pkg::aual_setup_s SETUP,
  input wire aual_pkg::aual_adj_s ADJ_REQ,
  input wire logic ADJ_APPLY,
  input wire logic [15:0] ADJ_LIVE,
  input wire logic [13:0] RD_WORD,
  output logic [15:0] RD_DATA,
  output logic [15:0] STATUS_WORD,
  output logic [15:0] MON_WORD,
  output logic [N_IN*16-1:0] CONV_OUT,
  output logic [N_OUT*16-1:0] ANA_OUT,
  output logic ADJ_ACCEPT,
  output logic RUN_LED,
  output logic UNIT_ALARM_LED,
  output logic TRIM_MODE_LED,
  output logic HOST_FAULT_LED
);

  // ==========================================
  // condition decode
  logic [N_IN-1:0] wire_err;
  logic [N_OUT-1:0] out_err;
  logic adj_mode;
  logic plc_err;
  logic bcd_ok;
  logic [3:0] setup_err;
  logic chan_ok;
  logic [13:0] base_word;

  // per-input broken wire, only in the live-zero range
  for (genvar i = 0; i < N_IN; i++) begin : g_wire
    assign wire_err[i] = IN_WIRE_OPEN[i] && (IN_RANGE[i*2 +: 2] == aual_pkg::AUAL_RNG_1_5V);
  end
  assign out_err = OUT_OVER;
  assign adj_mode = ADJ_SWITCH;
  assign plc_err = adj_mode && HOST_PROG_MODE;
  assign bcd_ok = (SETUP.ratio_val[3:0] < 4'hA) && (SETUP.ratio_val[7:4] < 4'hA)
    && (SETUP.ratio_val[11:8] < 4'hA) && (SETUP.ratio_val[15:12] < 4'hA);
  assign chan_ok = ADJ_REQ.chan_enabled && (((ADJ_REQ.chan >= 8'h11) && (ADJ_REQ.chan <= 8'h14))
    || ((ADJ_REQ.chan >= 8'h21) && (ADJ_REQ.chan <= 8'h24)));
  assign base_word = 14'(aual_pkg::BASE_WORD + aual_pkg::UNIT_STRIDE * UNIT_NUM);
  always_comb begin
    setup_err = 4'h0;
    setup_err[0] = SETUP.ratio_use && !SETUP.ratio_chan_used;
    setup_err[1] = SETUP.ratio_use && !bcd_ok;
    setup_err[2] = SETUP.hold_sel > aual_pkg::HOLD_SEL_MAX;
    setup_err[3] = SETUP.avg_sel > aual_pkg::AVG_SEL_MAX;
  end

  // ==========================================
  // sticky flags: setup faults latch until restart, nv fail until commit retry or adjust mode exit
  logic [3:0] setup_flag;
  logic [3:0] next_setup_flag;
  logic nv_flag;
  logic next_nv_flag;
  logic [1:0] adj_flag;
  logic [1:0] next_adj_flag;
  logic setup_bad;
  logic next_setup_bad;

  // setup flags: a restart clears, but a standing cause sets again (set wins)
  always_comb begin
    next_setup_flag = RESTART ? 4'h0 : setup_flag;
    next_setup_flag = next_setup_flag | setup_err[3:0];
    next_setup_bad = |next_setup_flag;
    // nv write failure held until the host toggles commit again or adjustment mode ends
    next_nv_flag = nv_flag;
    if (!adj_mode || ADJ_APPLY) begin
      next_nv_flag = 1'b0;
    end
    if (adj_mode && ADJ_REQ.nv_fail) begin
      next_nv_flag = 1'b1;
    end
    // adjust range/channel errors follow the current request
    next_adj_flag = 2'h0;
    next_adj_flag[0] = adj_mode && !plc_err && !ADJ_REQ.in_window;
    next_adj_flag[1] = adj_mode && !plc_err && !chan_ok;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      setup_flag <= 4'h0;
      nv_flag <= 1'b0;
      adj_flag <= 2'h0;
      setup_bad <= 1'b0;
    end else begin
      setup_flag <= next_setup_flag;
      nv_flag <= next_nv_flag;
      adj_flag <= next_adj_flag;
      setup_bad <= next_setup_bad;
    end
  end

  // ==========================================
  // status word, data paths and indicators
  logic [15:0] next_status;
  logic [15:0] next_rd;
  logic [15:0] next_mon;
  logic [N_IN*16-1:0] next_conv;
  logic [N_OUT*16-1:0] next_ana;
  logic next_accept;
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink;
  logic next_blink;
  logic next_run;
  logic next_alarm;
  logic next_trim;
  logic next_host;

  always_comb begin
    next_status = aual_pkg::STATUS_RST;
    if (plc_err) begin
      next_status[aual_pkg::ADJ_MODE_BIT] = 1'b1;
    end else begin
      // output/wire flags drop with their cause; setup and nv flags come from the sticky registers
      next_status[aual_pkg::OUT_ERR_LSB +: 4] = out_err[3:0];
      next_status[aual_pkg::WIRE_ERR_LSB +: 4] = wire_err[3:0];
      next_status[aual_pkg::RATIO_USE_BIT] = setup_flag[0];
      next_status[aual_pkg::RATIO_VAL_BIT] = setup_flag[1];
      next_status[aual_pkg::HOLD_SEL_BIT] = setup_flag[2];
      next_status[aual_pkg::AVG_SEL_BIT] = setup_flag[3];
      next_status[aual_pkg::ADJ_RANGE_BIT] = adj_flag[0];
      next_status[aual_pkg::ADJ_CHAN_BIT] = adj_flag[1];
      next_status[aual_pkg::NV_FAIL_BIT] = nv_flag;
      next_status[aual_pkg::ADJ_MODE_BIT] = adj_mode;
    end
    next_rd = (RD_WORD == base_word + 14'(aual_pkg::ALARM_WORD_OFS)) ? STATUS_WORD
      : (RD_WORD == base_word + 14'(aual_pkg::MON_WORD_OFS)) ? MON_WORD : 16'h0000;
    // conversion: frozen on plc error, 0000 on setup fault or broken wire
    next_conv = CONV_OUT;
    next_ana = ANA_OUT;
    for (int i = 0; i < N_IN; i++) begin
      if (!plc_err) begin
        next_conv[i*16 +: 16] = (setup_bad || wire_err[i]) ? aual_pkg::ZERO_DATA
          : IN_DATA[i*16 +: 16];
      end
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (plc_err || nv_flag) begin
        next_ana[i*16 +: 16] = ANA_OUT[i*16 +: 16];
      end else if (setup_bad) begin
        next_ana[i*16 +: 16] = aual_pkg::ZERO_DATA;
      end else if (out_err[i]) begin
        next_ana[i*16 +: 16] = OUT_HOLD_VAL[i*16 +: 16];
      end else begin
        next_ana[i*16 +: 16] = OUT_SET[i*16 +: 16];
      end
    end
    // adjustment acceptance and monitor word
    next_accept = ADJ_APPLY && adj_mode && !plc_err && chan_ok && ADJ_REQ.in_window;
    next_mon = MON_WORD;
    if (adj_mode && !plc_err && chan_ok) begin
      next_mon = ADJ_LIVE;
    end
    // blink counter for the adjust lamp
    next_blink_cnt = blink_cnt + 32'h1;
    next_blink = blink;
    if (!adj_mode) begin
      next_blink_cnt = 32'h0;
      next_blink = 1'b1;
    end else if (blink_cnt >= BLINK_CYCLES - 1) begin
      next_blink_cnt = 32'h0;
      next_blink = !blink;
    end
    next_trim = adj_mode && blink;
    next_run = HOST_OK && !setup_bad && !plc_err;
    next_alarm = |next_status[7:0] || |next_status[14:8] || setup_bad;
    next_host = HOST_FAULT;
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      STATUS_WORD <= aual_pkg::STATUS_RST;
      RD_DATA <= 16'h0000;
      MON_WORD <= 16'h0000;
      CONV_OUT <= '0;
      ANA_OUT <= '0;
      ADJ_ACCEPT <= 1'b0;
      blink_cnt <= 32'h0;
      blink <= 1'b1;
      RUN_LED <= 1'b0;
      UNIT_ALARM_LED <= 1'b0;
      TRIM_MODE_LED <= 1'b0;
      HOST_FAULT_LED <= 1'b0;
    end else begin
      STATUS_WORD <= next_status;
      RD_DATA <= next_rd;
      MON_WORD <= next_mon;
      CONV_OUT <= next_conv;
      ANA_OUT <= next_ana;
      ADJ_ACCEPT <= next_accept;
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      RUN_LED <= next_run;
      UNIT_ALARM_LED <= next_alarm;
      TRIM_MODE_LED <= next_trim;
      HOST_FAULT_LED <= next_host;
    end
  end

  // ==========================================
  // assertions
  // lamps follow their causes one cycle later
  a_run_lamp: assert property (@(posedge MCLK) disable iff (!RST_B)
    !HOST_OK |=> !RUN_LED)
    else $error("run lamp lit without host exchange");
  a_alarm_wire: assert property (@(posedge MCLK) disable iff (!RST_B)
    !plc_err && (|wire_err) |=> UNIT_ALARM_LED)
    else $error("alarm lamp dark with broken wire");
  a_alarm_dark: assert property (@(posedge MCLK) disable iff (!RST_B)
    !(|out_err) && !(|wire_err) && !setup_bad && !nv_flag && adj_flag == 2'h0
    |=> !UNIT_ALARM_LED)
    else $error("alarm lamp lit with no alarm");
  a_host_on: assert property (@(posedge MCLK) disable iff (!RST_B)
    HOST_FAULT |=> HOST_FAULT_LED)
    else $error("host fault lamp dark on fault");
  a_host_off: assert property (@(posedge MCLK) disable iff (!RST_B)
    !HOST_FAULT |=> !HOST_FAULT_LED)
    else $error("host fault lamp lit without fault");
  a_trim_dark: assert property (@(posedge MCLK) disable iff (!RST_B)
    !adj_mode |=> !TRIM_MODE_LED)
    else $error("adjust lamp lit outside adjust");
  a_run_dark: assert property (@(posedge MCLK) disable iff (!RST_B)
    setup_bad |=> !RUN_LED && UNIT_ALARM_LED)
    else $error("setup fault lamps wrong");
  // live flags: set and dropped with their cause
  a_wire_flag: assert property (@(posedge MCLK) disable iff (!RST_B)
    !plc_err && wire_err[0] |=> STATUS_WORD[4] && CONV_OUT[15:0] == 16'h0000)
    else $error("broken wire not flagged or data not zero");
  a_wire_range: assert property (@(posedge MCLK) disable iff (!RST_B)
    IN_RANGE[1:0] != 2'h2 |=> !STATUS_WORD[4])
    else $error("wire check in wrong range");
  a_out_hold: assert property (@(posedge MCLK) disable iff (!RST_B)
    out_err[0] && !plc_err && !nv_flag && !setup_bad
    |=> ANA_OUT[15:0] == $past(OUT_HOLD_VAL[15:0]))
    else $error("output not at hold value");
  a_self_clear: assert property (@(posedge MCLK) disable iff (!RST_B)
    $fell(OUT_OVER[0]) |=> !STATUS_WORD[0])
    else $error("output flag not cleared");
  a_multi_flags: assert property (@(posedge MCLK) disable iff (!RST_B)
    !plc_err && out_err[0] && wire_err[1] |=> STATUS_WORD[0] && STATUS_WORD[5])
    else $error("independent flags not both set");
  // latched setup flags: two cycles through the flag register
  a_setup_sticky: assert property (@(posedge MCLK) disable iff (!RST_B)
    setup_flag[2] && !RESTART |=> setup_flag[2])
    else $error("setup flag cleared without restart");
  a_ratio_use: assert property (@(posedge MCLK) disable iff (!RST_B)
    SETUP.ratio_use && !SETUP.ratio_chan_used ##1 !plc_err |=> STATUS_WORD[8])
    else $error("ratio channel error missed");
  a_ratio_bcd: assert property (@(posedge MCLK) disable iff (!RST_B)
    SETUP.ratio_use && (SETUP.ratio_val[11:8] > 4'h9) ##1 !plc_err |=> STATUS_WORD[9])
    else $error("ratio value error missed");
  a_hold_code: assert property (@(posedge MCLK) disable iff (!RST_B)
    SETUP.hold_sel > 16'h0002 |=> ##1 (STATUS_WORD[10] || $past(plc_err)))
    else $error("hold code error missed");
  a_avg_code: assert property (@(posedge MCLK) disable iff (!RST_B)
    SETUP.avg_sel > 16'h0006 ##1 !plc_err |=> STATUS_WORD[11])
    else $error("averaging code error missed");
  a_setup_zero: assert property (@(posedge MCLK) disable iff (!RST_B)
    setup_bad && !plc_err |=> CONV_OUT == '0)
    else $error("conversion not zero on setup fault");
  // adjustment mode flags and data
  a_adj_mode: assert property (@(posedge MCLK) disable iff (!RST_B)
    adj_mode |=> STATUS_WORD[15])
    else $error("adjust mode flag missing");
  a_adj_window: assert property (@(posedge MCLK) disable iff (!RST_B)
    adj_mode && !plc_err && !ADJ_REQ.in_window ##1 !plc_err
    |=> STATUS_WORD[12] && UNIT_ALARM_LED)
    else $error("window alarm not shown");
  a_mon_live: assert property (@(posedge MCLK) disable iff (!RST_B)
    adj_mode && !plc_err && chan_ok |=> MON_WORD == $past(ADJ_LIVE))
    else $error("monitor word not live");
  a_chan_reject: assert property (@(posedge MCLK) disable iff (!RST_B)
    !chan_ok |=> !ADJ_ACCEPT)
    else $error("bad channel accepted");
  a_nv_hold: assert property (@(posedge MCLK) disable iff (!RST_B)
    nv_flag && !plc_err |=> STATUS_WORD[14] && $stable(ANA_OUT))
    else $error("write failure not held");
  a_plc_alone: assert property (@(posedge MCLK) disable iff (!RST_B)
    plc_err |=> STATUS_WORD == 16'h8000)
    else $error("plc error word wrong");
  a_plc_freeze: assert property (@(posedge MCLK) disable iff (!RST_B)
    plc_err |=> $stable(ANA_OUT) && $stable(CONV_OUT))
    else $error("data changed during plc error");
  a_read_status: assert property (@(posedge MCLK) disable iff (!RST_B)
    RD_WORD == 14'(aual_pkg::BASE_WORD + aual_pkg::UNIT_STRIDE * UNIT_NUM + aual_pkg::ALARM_WORD_OFS)
    |=> RD_DATA == $past(STATUS_WORD))
    else $error("status word read wrong");
  // scenario covers
  c_wire: cover property (@(posedge MCLK) disable iff (!RST_B) STATUS_WORD[4]);
  c_nv_fail: cover property (@(posedge MCLK) disable iff (!RST_B) STATUS_WORD[14]);
  c_setup: cover property (@(posedge MCLK) disable iff (!RST_B) setup_bad ##1 RESTART);
  c_plc: cover property (@(posedge MCLK) disable iff (!RST_B) STATUS_WORD == 16'h8000);
  c_accept: cover property (@(posedge MCLK) disable iff (!RST_B) ADJ_ACCEPT);

endmodule : aual_status

`default_nettype wire

// [aual_status_tb_top.sv]
// testbench: drives the alarm block, queues expected results, watcher compares
// assumes the host model supplies read address and commit pulses
`timescale 1ns/1ps
`default_nettype none
module aual_status_tb_top;
  typedef struct {int kind; logic [63:0] val;} aual_note_s;
  localparam aual_pkg::aual_setup_s good_setup = '{16'h9999, 16'h0002, 16'h0006, 1'b0, 1'b0};
  logic mclk = 1'b0, rst_b = 1'b0, restart = 1'b0, host_ok = 1'b1, host_fault = 1'b0;
  logic adj_sw = 1'b0, prog = 1'b0, commit = 1'b0, trim_q = 1'b0;
  logic [6:0] unit = 7'h00;
  logic [3:0] ofs = 4'h9, wire_open = 4'h0, over = 4'h0;
  logic [7:0] rng = {4{aual_pkg::AUAL_RNG_1_5V}};
  logic [63:0] in_data = 64'h0, out_set = 64'h0, hold_val = 64'h0, conv, ana, old;
  aual_pkg::aual_setup_s setup = good_setup;
  aual_pkg::aual_adj_s trim_mode_led = '{8'h11, 1'b1, 1'b1, 1'b0};
  logic [15:0] live = 16'h0000, rd_data, status, mon;
  logic [13:0] rd_word;
  logic apply, accept, run_led, alarm_led, trim_led, fault_led;
  int n_errors = 0, n_checks = 0, n_acc = 0, n_blink = 0, i, j;
  aual_note_s notes[$];
  aual_note_s cur;
  aual_host_model i_host (.MCLK(mclk), .RST_B(rst_b), .unit_num(unit), .rd_ofs(ofs),
    .commit_req(commit), .rd_word(rd_word), .adj_apply(apply));
  aual_status #(.BLINK_CYCLES(4)) i_dut (.MCLK(mclk), .RST_B(rst_b), .RESTART(restart),
    .UNIT_NUM(unit), .HOST_OK(host_ok), .HOST_FAULT(host_fault), .ADJ_SWITCH(adj_sw),
    .HOST_PROG_MODE(prog), .IN_RANGE(rng), .IN_WIRE_OPEN(wire_open), .IN_DATA(in_data),
    .OUT_OVER(over), .OUT_SET(out_set), .OUT_HOLD_VAL(hold_val), .SETUP(setup),
    .ADJ_REQ(trim_mode_led), .ADJ_APPLY(apply), .ADJ_LIVE(live), .RD_WORD(rd_word),
    .RD_DATA(rd_data), .STATUS_WORD(status), .MON_WORD(mon), .CONV_OUT(conv),
    .ANA_OUT(ana), .ADJ_ACCEPT(accept), .RUN_LED(run_led), .UNIT_ALARM_LED(alarm_led),
    .TRIM_MODE_LED(trim_led), .HOST_FAULT_LED(fault_led));
  // ========================================
  // clock, watchdog
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #400us;
    n_errors++;
    final_report();
  end
  task automatic chk(input string name, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task automatic final_report;
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic note(input int k, input logic [63:0] v);
    notes.push_back('{k, v});
  endtask : note
  task automatic settle;
    repeat (3) @(negedge mclk);
  endtask : settle
  task automatic pulse_commit;
    commit = 1'b1;
    @(negedge mclk);
    commit = 1'b0;
    settle();
  endtask : pulse_commit
  // ========================================
  // event counters and watcher comparing every queued note, oldest first
  always @(posedge mclk) begin
    if (accept === 1'b1) n_acc++;
    if (trim_led !== trim_q) n_blink++;
    trim_q <= trim_led;
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      case (cur.kind)
        0: chk("status word", cur.val, {48'h0, status});
        1: chk("alarm and fault lamps", cur.val, {62'h0, alarm_led, fault_led});
        2: chk("read data", cur.val, {48'h0, rd_data});
        3: chk("conversion out", cur.val, conv);
        4: chk("analog out", cur.val, ana);
        5: chk("monitor word", cur.val, {48'h0, mon});
        6: chk("run lamp", cur.val, {63'h0, run_led});
        7: chk("accept count", cur.val, 64'(n_acc));
        default: chk("adjust lamp flashed", cur.val, {63'h0, n_blink != 0});
      endcase
    end
  end
  // ========================================
  // main sequence
  initial begin
    void'($urandom(32'h87E6));
    i = $urandom % 4;
    j = $urandom % 4;
    unit = 7'($urandom % 96);
    in_data = {$urandom, $urandom};
    out_set = {$urandom, $urandom};
    hold_val = {$urandom, $urandom};
    live = 16'($urandom);
    repeat (6) @(negedge mclk);
    note(0, 64'h0);
    note(6, 64'h0);
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    settle();
    note(6, 64'h1);
    note(0, 64'h0);
    note(8, 64'h0);
    wire_open[i] = 1'b1;
    settle();
    note(0, 64'(16'h0010 << i));
    note(1, 64'h2);
    note(3, in_data & ~(64'hFFFF << 16 * i));
    note(2, 64'(16'h0010 << i));
    ofs = 4'h5;
    rng[2 * i +: 2] = aual_pkg::AUAL_RNG_10V;
    settle();
    note(2, 64'h0);
    note(0, 64'h0);
    rng[2 * i +: 2] = aual_pkg::AUAL_RNG_1_5V;
    over[j] = 1'b1;
    settle();
    note(0, 64'((16'h0010 << i) | (16'h0001 << j)));
    note(4, (out_set & ~(64'hFFFF << 16 * j)) | (hold_val & (64'hFFFF << 16 * j)));
    over = 4'h0;
    settle();
    note(0, 64'(16'h0010 << i));
    wire_open = 4'h0;
    host_fault = 1'b1;
    settle();
    note(1, 64'h1);
    host_fault = 1'b0;
    host_ok = 1'b0;
    settle();
    note(6, 64'h0);
    note(1, 64'h0);
    host_ok = 1'b1;
    adj_sw = 1'b1;
    pulse_commit();
    repeat (12) @(negedge mclk);
    note(0, 64'h8000);
    note(7, 64'h1);
    note(8, 64'h1);
    trim_mode_led.chan = 8'h15;
    pulse_commit();
    note(0, 64'hA000);
    note(7, 64'h1);
    ofs = 4'h8;
    trim_mode_led = '{8'h21, 1'b1, 1'b0, 1'b0};
    pulse_commit();
    note(0, 64'h9000);
    note(5, {48'h0, live});
    note(2, {48'h0, live});
    note(7, 64'h1);
    trim_mode_led.in_window = 1'b1;
    trim_mode_led.nv_fail = 1'b1;
    old = ana;
    pulse_commit();
    out_set = ~out_set;
    settle();
    note(0, 64'hC000);
    note(4, old);
    trim_mode_led.nv_fail = 1'b0;
    pulse_commit();
    note(0, 64'h8000);
    prog = 1'b1;
    trim_mode_led.chan = 8'h15;
    settle();
    in_data = ~in_data;
    old = ana;
    out_set = ~out_set;
    settle();
    note(0, 64'h8000);
    note(4, old);
    note(3, ~in_data);
    prog = 1'b0;
    adj_sw = 1'b0;
    trim_mode_led.chan = 8'h11;
    settle();
    note(0, 64'h0);
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: setup.ratio_use = 1'b1;
        1: setup = '{16'h9A00, 16'h0002, 16'h0006, 1'b1, 1'b1};
        2: setup.hold_sel = 16'h0003;
        default: setup.avg_sel = 16'h0007;
      endcase
      settle();
      note(0, 64'(16'h0100 << k));
      note(3, 64'h0);
      note(6, 64'h0);
      note(1, 64'h2);
      setup = good_setup;
      settle();
      note(0, 64'(16'h0100 << k));
      restart = 1'b1;
      @(negedge mclk);
      restart = 1'b0;
      settle();
      note(0, 64'h0);
      note(6, 64'h1);
    end
    settle();
    final_report();
  end
endmodule : aual_status_tb_top
`default_nettype wire
